// ---- sfcb_pkg.sv ----
// Constants, types and register map of the serial format and control block
// How it works
// - Parity on adds a parity bit to sent characters and checks received ones except in synchronous mode.
// - Parity sense applies only with parity on: zero even, one odd.
// - In card mode the bit clock count gives 32, 64, 372 or 256 clocks per bit.
// - Clock source code 00 feeds the undivided system clock.
// - Clock source 01 feeds system clock over 4, code 11 over 64.
// - Transmit request follows enable and empty flag; clearing either withdraws it.
// - Receive and error requests follow enable and receive flags; clearing withdraws them.
// - With transmit on, sending starts once data is written and empty is cleared.
// - With transmit off the empty flag is held at one.
// - Turning receive off leaves all receive status flags as they are.
// - Card mode select changes the meaning of some format bits.
package sfcb_pkg;
  // Bus geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int CHAR_W = 8;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFS_FORMAT   = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_CONTROL  = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_STATUS   = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_TXDATA   = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_RXDATA   = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_CARD     = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 8'h1C;
  // Field layouts
  typedef struct packed {
    logic       syncMode;
    logic       spare;
    logic       parityOn;
    logic       parityOdd;
    logic [1:0] bitClockCount;
    logic [1:0] brgSource;
  } sfcb_fmt_t;
  typedef struct packed {
    logic       txIrqEn;
    logic       rxIrqEn;
    logic       txOn;
    logic       rxOn;
    logic [3:0] spare;
  } sfcb_ctl_t;
  typedef struct packed {
    logic       txEmpty;
    logic       rxFull;
    logic       overrun;
    logic       framingErr;
    logic       parityErr;
    logic [2:0] rsv;
  } sfcb_stat_t;
  typedef struct packed {
    logic rxErr;
    logic rx;
    logic tx;
  } sfcb_irq_t;
  // Reset values and masks
  localparam logic [7:0] FORMAT_RST   = 8'h00;
  localparam logic [7:0] CONTROL_RST  = 8'h00;
  localparam logic [7:0] STATUS_RST   = 8'h80;
  localparam logic [7:0] STAT_FLAGS   = 8'hF8;
  localparam logic [7:0] STAT_TXE     = 8'h80;
  localparam logic [2:0] IRQ_RST      = 3'h0;
  localparam logic [7:0] CHAR_RST     = 8'h00;
  // Basic clocks per bit
  localparam logic [1:0] BCC_32  = 2'h0;
  localparam logic [1:0] BCC_64  = 2'h1;
  localparam logic [1:0] BCC_372 = 2'h2;
  localparam logic [1:0] BCC_256 = 2'h3;
  localparam logic [8:0] BCLK_32   = 9'h020;
  localparam logic [8:0] BCLK_64   = 9'h040;
  localparam logic [8:0] BCLK_372  = 9'h174;
  localparam logic [8:0] BCLK_256  = 9'h100;
  localparam logic [8:0] BCLK_NORM = 9'h010;
  // Baud generator sources, last count of each divider
  localparam logic [1:0] BRG_DIV1  = 2'h0;
  localparam logic [1:0] BRG_DIV4  = 2'h1;
  localparam logic [1:0] BRG_DIV16 = 2'h2;
  localparam logic [1:0] BRG_DIV64 = 2'h3;
  localparam logic [5:0] PRE_LAST1  = 6'h00;
  localparam logic [5:0] PRE_LAST4  = 6'h03;
  localparam logic [5:0] PRE_LAST16 = 6'h0F;
  localparam logic [5:0] PRE_LAST64 = 6'h3F;
  // Frame shape
  localparam logic [3:0] FRAME_PAR   = 4'hB;
  localparam logic [3:0] FRAME_NOPAR = 4'hA;
  localparam logic [3:0] LAST_DATA   = 4'h7;
  localparam logic [3:0] PAR_SLOT    = 4'h2;
  // Line state machines
  typedef enum logic [1:0] {TX_IDLE = 2'h0, TX_RUN = 2'h1} sfcb_tx_t;
  typedef enum logic [2:0] {
    RX_IDLE  = 3'h0,
    RX_START = 3'h1,
    RX_DATA  = 3'h3,
    RX_PAR   = 3'h2,
    RX_STOP  = 3'h6
  } sfcb_rx_t;
endpackage : sfcb_pkg

// ---- sfcb_parity.sv ----
// Parity generator for one character
`timescale 1ns/1ps
module sfcb_parity #(
  parameter int WIDTH = sfcb_pkg::CHAR_W
) (
  // Character and sense
  input  wire logic [WIDTH-1:0] data,
  input  wire logic             odd,
  // Parity bit
  output wire logic             parity
);
  // Odd sense inverts the even result
  assign parity = (^data) ^ odd;
endmodule : sfcb_parity

// ---- sfcb_prescale.sv ----
// Baud generator input clock divider
`timescale 1ns/1ps
module sfcb_prescale (
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       rst,
  // Source select and tick
  input  wire logic [1:0] brgSource,
  output wire logic       tick
);
  import sfcb_pkg::*;
  logic [5:0] cnt_r;
  logic [5:0] cnt_nxt;
  wire  logic [5:0] lastCnt;
  // Divider end count per source code
  assign lastCnt = (brgSource == BRG_DIV1)  ? PRE_LAST1 :
                   (brgSource == BRG_DIV4)  ? PRE_LAST4 :
                   (brgSource == BRG_DIV16) ? PRE_LAST16 :
                   PRE_LAST64;
  // Greater-or-equal so a source change never stalls the counter
  assign tick    = (cnt_r >= lastCnt);
  assign cnt_nxt = tick ? PRE_LAST1 : cnt_r + 6'h01;
  ////////////////////////////////////////////////////////////////////////////
  // Counter
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      cnt_r <= PRE_LAST1;
    else
      cnt_r <= cnt_nxt;
  end
endmodule : sfcb_prescale

// ---- sfcb_top.sv ----
// Serial format and control registers with line logic behind an AXI4-Lite slave
`timescale 1ns/1ps
module sfcb_top (
  // Clock and reset
  input  wire logic                        clock,
  input  wire logic                        rst,
  // AXI4-Lite write
  input  wire logic [sfcb_pkg::ADDR_W-1:0] awaddr,
  input  wire logic                        awvalid,
  output wire logic                        awready,
  input  wire logic [sfcb_pkg::DATA_W-1:0] wdata,
  input  wire logic [3:0]                  wstrb,
  input  wire logic                        wvalid,
  output wire logic                        wready,
  output logic      [1:0]                  bresp,
  output logic                             bvalid,
  input  wire logic                        bready,
  // AXI4-Lite read
  input  wire logic [sfcb_pkg::ADDR_W-1:0] araddr,
  input  wire logic                        arvalid,
  output wire logic                        arready,
  output logic      [sfcb_pkg::DATA_W-1:0] rdata,
  output logic      [1:0]                  rresp,
  output logic                             rvalid,
  input  wire logic                        rready,
  // Serial line
  output logic                             txd,
  input  wire logic                        rxd,
  input  wire logic                        sclkIn,
  // Interrupts
  output wire logic                        txIrq,
  output wire logic                        rxIrq,
  output wire logic                        rxErrIrq,
  output wire logic                        irq
);
  import sfcb_pkg::*;
  sfcb_fmt_t          format_r;
  sfcb_ctl_t          control_r;
  sfcb_stat_t         status_r;
  sfcb_stat_t         armed_r;
  sfcb_irq_t          irqStat_r;
  sfcb_irq_t          irqMask_r;
  sfcb_irq_t          irqLvlPrev_r;
  logic               cardSel_r;
  logic [CHAR_W-1:0]  txData_r;
  logic [CHAR_W-1:0]  rxData_r;
  logic               awHeld_r;
  logic               wHeld_r;
  logic [ADDR_W-1:0]  awAddr_r;
  logic [7:0]         wData_r;
  logic               wLane0_r;
  sfcb_tx_t           txState_r;
  logic [8:0]         txCnt_r;
  logic [10:0]        txShift_r;
  logic [3:0]         txLeft_r;
  logic               txFramePar_r;
  logic [CHAR_W-1:0]  txSentData_r;
  logic               txSentOdd_r;
  sfcb_rx_t           rxState_r;
  logic [8:0]         rxCnt_r;
  logic [3:0]         rxBit_r;
  logic [CHAR_W-1:0]  rxShift_r;
  logic               rxPar_r;
  logic               rxdPrev_r;
  logic               sclkPrev_r;
  ////////////////////////////////////////////////////////////////////////////
  // Bus decode
  wire logic doWrite  = awHeld_r && wHeld_r && !bvalid;
  wire logic wrLane   = doWrite && wLane0_r;
  wire logic wrFormat = wrLane && (awAddr_r == OFS_FORMAT);
  wire logic wrCtl    = wrLane && (awAddr_r == OFS_CONTROL);
  wire logic wrStatus = wrLane && (awAddr_r == OFS_STATUS);
  wire logic wrTxData = wrLane && (awAddr_r == OFS_TXDATA);
  wire logic wrCard   = wrLane && (awAddr_r == OFS_CARD);
  wire logic wrIrqSt  = wrLane && (awAddr_r == OFS_IRQ_STAT);
  wire logic wrIrqMsk = wrLane && (awAddr_r == OFS_IRQ_MASK);
  wire logic wrMapped = (awAddr_r == OFS_FORMAT) || (awAddr_r == OFS_CONTROL) || (awAddr_r == OFS_STATUS) ||
                        (awAddr_r == OFS_TXDATA) || (awAddr_r == OFS_RXDATA) || (awAddr_r == OFS_CARD) ||
                        (awAddr_r == OFS_IRQ_STAT) || (awAddr_r == OFS_IRQ_MASK);
  wire logic rdTake   = arvalid && arready;
  wire logic rdStatus = rdTake && (araddr == OFS_STATUS);
  wire logic [7:0] rdByte =
    (araddr == OFS_FORMAT)   ? format_r :
    (araddr == OFS_CONTROL)  ? control_r :
    (araddr == OFS_STATUS)   ? status_r :
    (araddr == OFS_TXDATA)   ? txData_r :
    (araddr == OFS_RXDATA)   ? rxData_r :
    (araddr == OFS_CARD)     ? {7'h00, cardSel_r} :
    (araddr == OFS_IRQ_STAT) ? {5'h00, irqStat_r} :
    (araddr == OFS_IRQ_MASK) ? {5'h00, irqMask_r} : 8'h00;
  wire logic rdMapped = (araddr[1:0] == 2'h0) && (araddr <= OFS_IRQ_MASK);
  // Holding registers accept one beat each until the response is taken
  assign awready = !awHeld_r && !bvalid;
  assign wready  = !wHeld_r && !bvalid;
  assign arready = !rvalid;
  ////////////////////////////////////////////////////////////////////////////
  // Baud clock, bit time and parity
  wire logic brgTick;
  wire logic txParity;
  wire logic rxParity;
  sfcb_prescale u_prescale (
    .clock     (clock),
    .rst       (rst),
    .brgSource (format_r.brgSource),
    .tick      (brgTick)
  );
  // Normal mode ignores the card bit clock count
  wire logic [8:0] bitLen =
    !cardSel_r                           ? BCLK_NORM :
    (format_r.bitClockCount == BCC_32)   ? BCLK_32 :
    (format_r.bitClockCount == BCC_64)   ? BCLK_64 :
    (format_r.bitClockCount == BCC_372)  ? BCLK_372 : BCLK_256;
  wire logic [8:0] bitLast = bitLen - 9'h001;
  wire logic syncMode = format_r.syncMode && !cardSel_r;
  sfcb_parity u_txPar (
    .data   (txData_r),
    .odd    (format_r.parityOdd),
    .parity (txParity)
  );
  ////////////////////////////////////////////////////////////////////////////
  // Transmitter
  wire logic txStart = (txState_r == TX_IDLE) && control_r.txOn && !status_r.txEmpty;
  wire logic txBitEnd = (txState_r == TX_RUN) && brgTick && (txCnt_r == 9'h000);
  wire logic txLastBit = txBitEnd && (txLeft_r == 4'h1);
  // Stop bit doubles as the parity slot when parity is off
  wire logic [10:0] txFrame = {1'b1, format_r.parityOn ? txParity : 1'b1, txData_r, 1'b0};
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      txState_r <= TX_IDLE;
      txCnt_r   <= 9'h000;
      txShift_r <= 11'h7FF;
      txLeft_r  <= 4'h0;
      txd       <= 1'b1;
    end
    else if (txStart)
    begin
      txState_r <= TX_RUN;
      txCnt_r   <= bitLast;
      txShift_r <= txFrame;
      txLeft_r  <= format_r.parityOn ? FRAME_PAR : FRAME_NOPAR;
      txd       <= txFrame[0];
    end
    else if (txBitEnd)
    begin
      txState_r <= txLastBit ? TX_IDLE : TX_RUN;
      txCnt_r   <= bitLast;
      txShift_r <= {1'b1, txShift_r[10:1]};
      txLeft_r  <= txLeft_r - 4'h1;
      txd       <= txLastBit ? 1'b1 : txShift_r[1];
    end
    else if ((txState_r == TX_RUN) && brgTick)
      txCnt_r <= txCnt_r - 9'h001;
  end
  // Frame snapshot watched by the checks
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      txFramePar_r <= 1'b0;
      txSentData_r <= CHAR_RST;
      txSentOdd_r  <= 1'b0;
    end
    else if (txStart)
    begin
      txFramePar_r <= format_r.parityOn;
      txSentData_r <= txData_r;
      txSentOdd_r  <= format_r.parityOdd;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Receiver
  wire logic sclkRise   = sclkIn && !sclkPrev_r;
  wire logic rxIdle     = (rxState_r == RX_IDLE);
  wire logic rxStartAsy = rxIdle && control_r.rxOn && !syncMode && rxdPrev_r && !rxd;
  wire logic rxStartSyn = rxIdle && control_r.rxOn && syncMode && sclkRise;
  // Sampling stops with receive off so flags cannot move afterwards
  wire logic rxSample = control_r.rxOn && !rxIdle &&
                        (syncMode ? sclkRise : (brgTick && (rxCnt_r == 9'h000)));
  wire logic rxLastData = rxSample && (rxState_r == RX_DATA) && (rxBit_r == LAST_DATA);
  wire logic rxSyncDone = rxLastData && syncMode;
  wire logic rxAsyDone  = rxSample && (rxState_r == RX_STOP);
  wire logic rxDone     = rxSyncDone || rxAsyDone;
  wire logic [CHAR_W-1:0] rxWord = rxSyncDone ? {rxd, rxShift_r[7:1]} : rxShift_r;
  sfcb_parity u_rxPar (
    .data   (rxWord),
    .odd    (format_r.parityOdd),
    .parity (rxParity)
  );
  // A character landing on a full buffer is dropped and flagged
  wire logic ovrSet    = rxDone && status_r.rxFull;
  wire logic rxFullSet = rxDone && !status_r.rxFull;
  wire logic ferSet    = rxFullSet && rxAsyDone && !rxd;
  wire logic perSet    = rxFullSet && rxAsyDone && format_r.parityOn && (rxPar_r != rxParity);
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      rxState_r <= RX_IDLE;
      rxCnt_r   <= 9'h000;
      rxBit_r   <= 4'h0;
      rxShift_r <= CHAR_RST;
      rxPar_r   <= 1'b0;
    end
    else if (!control_r.rxOn)
      rxState_r <= RX_IDLE;
    else if (rxStartAsy)
    begin
      rxState_r <= RX_START;
      rxCnt_r   <= {1'b0, bitLen[8:1]};
    end
    else if (rxStartSyn)
    begin
      rxState_r <= RX_DATA;
      rxShift_r <= {rxd, rxShift_r[7:1]};
      rxBit_r   <= 4'h1;
    end
    else if (rxSample)
    begin
      rxCnt_r <= bitLast;
      case (rxState_r)
        RX_START:
          rxState_r <= rxd ? RX_IDLE : RX_DATA;
        RX_DATA:
        begin
          rxShift_r <= {rxd, rxShift_r[7:1]};
          rxBit_r   <= rxBit_r + 4'h1;
          if (rxLastData)
            rxState_r <= syncMode ? RX_IDLE : (format_r.parityOn ? RX_PAR : RX_STOP);
        end
        RX_PAR:
        begin
          rxPar_r   <= rxd;
          rxState_r <= RX_STOP;
        end
        default:
          rxState_r <= RX_IDLE;
      endcase
      if (rxState_r == RX_START)
        rxBit_r <= 4'h0;
    end
    else if (!rxIdle && !syncMode && brgTick)
      rxCnt_r <= rxCnt_r - 9'h001;
  end
  ////////////////////////////////////////////////////////////////////////////
  // Status flags: clear needs a prior read of one, set wins over clear
  wire logic [7:0] statClr   = wrStatus ? (armed_r & ~wData_r & STAT_FLAGS) : 8'h00;
  wire logic [7:0] statSet   = {txStart, rxFullSet, ovrSet, ferSet, perSet, 3'h0};
  wire logic [7:0] statForce = control_r.txOn ? 8'h00 : STAT_TXE;
  wire logic [7:0] statNxt   = ((status_r & ~statClr) | statSet | statForce) & STAT_FLAGS;
  wire logic [7:0] armNxt    = ((rdStatus ? (armed_r | status_r) : armed_r) & ~statClr) & STAT_FLAGS;
  // Interrupt levels and sticky events
  assign txIrq    = control_r.txIrqEn && status_r.txEmpty;
  assign rxIrq    = control_r.rxIrqEn && status_r.rxFull;
  assign rxErrIrq = control_r.rxIrqEn && (status_r.overrun || status_r.framingErr || status_r.parityErr);
  wire sfcb_irq_t irqLvl  = '{rxErr: rxErrIrq, rx: rxIrq, tx: txIrq};
  wire logic [2:0] irqRise = irqLvl & ~irqLvlPrev_r;
  wire logic [2:0] irqClr  = wrIrqSt ? wData_r[2:0] : 3'h0;
  assign irq = |(irqStat_r & irqMask_r);
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      status_r     <= STATUS_RST;
      armed_r      <= 8'h00;
      irqStat_r    <= IRQ_RST;
      irqLvlPrev_r <= IRQ_RST;
      rxData_r     <= CHAR_RST;
      rxdPrev_r    <= 1'b1;
      sclkPrev_r   <= 1'b0;
    end
    else
    begin
      status_r     <= statNxt;
      armed_r      <= armNxt;
      irqStat_r    <= (irqStat_r & ~irqClr) | irqRise;
      irqLvlPrev_r <= irqLvl;
      rxdPrev_r    <= rxd;
      sclkPrev_r   <= sclkIn;
      if (rxFullSet)
        rxData_r <= rxWord;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Software registers
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      format_r  <= FORMAT_RST;
      control_r <= CONTROL_RST;
      cardSel_r <= 1'b0;
      txData_r  <= CHAR_RST;
      irqMask_r <= IRQ_RST;
    end
    else
    begin
      if (wrFormat)
        format_r <= wData_r;
      if (wrCtl)
        control_r <= wData_r;
      if (wrCard)
        cardSel_r <= wData_r[0];
      if (wrTxData)
        txData_r <= wData_r;
      if (wrIrqMsk)
        irqMask_r <= wData_r[2:0];
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite channels
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      awHeld_r <= 1'b0;
      wHeld_r  <= 1'b0;
      awAddr_r <= 8'h00;
      wData_r  <= 8'h00;
      wLane0_r <= 1'b0;
      bvalid   <= 1'b0;
      bresp    <= RESP_OKAY;
      rvalid   <= 1'b0;
      rresp    <= RESP_OKAY;
      rdata    <= 32'h00000000;
    end
    else
    begin
      if (awvalid && awready)
      begin
        awHeld_r <= 1'b1;
        awAddr_r <= awaddr;
      end
      if (wvalid && wready)
      begin
        wHeld_r  <= 1'b1;
        wData_r  <= wdata[7:0];
        wLane0_r <= wstrb[0];
      end
      if (doWrite)
      begin
        awHeld_r <= 1'b0;
        wHeld_r  <= 1'b0;
        bvalid   <= 1'b1;
        bresp    <= wrMapped ? RESP_OKAY : RESP_SLVERR;
      end
      else if (bvalid && bready)
        bvalid <= 1'b0;
      if (rdTake)
      begin
        rvalid <= 1'b1;
        rdata  <= {24'h000000, rdByte};
        rresp  <= rdMapped ? RESP_OKAY : RESP_SLVERR;
      end
      else if (rvalid && rready)
        rvalid <= 1'b0;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Checks
  wire logic src4  = (format_r.brgSource == BRG_DIV4);
  wire logic src16 = (format_r.brgSource == BRG_DIV16);
  wire logic [3:0] rxFlags = {status_r.rxFull, status_r.overrun, status_r.framingErr, status_r.parityErr};
  property p_txEmptyHeld;
    @(posedge clock) disable iff (rst) !control_r.txOn |=> status_r.txEmpty;
  endproperty
  a_txEmptyHeld: assert property (p_txEmptyHeld) else $error("empty flag dropped while transmit off");
  property p_txStart;
    @(posedge clock) disable iff (rst) txStart |=> (txState_r == TX_RUN) && status_r.txEmpty && !txd;
  endproperty
  a_txStart: assert property (p_txStart) else $error("transmit did not start with start bit");
  property p_parityBit;
    @(posedge clock) disable iff (rst)
      (txState_r == TX_RUN) && txFramePar_r && (txLeft_r == PAR_SLOT) |-> txd == ((^txSentData_r) ^ txSentOdd_r);
  endproperty
  a_parityBit: assert property (p_parityBit) else $error("wrong parity bit on line");
  property p_txIrqOff;
    @(posedge clock) disable iff (rst) $fell(control_r.txIrqEn) |-> !txIrq;
  endproperty
  a_txIrqOff: assert property (p_txIrqOff) else $error("transmit request kept after enable cleared");
  property p_rxIrqOff;
    @(posedge clock) disable iff (rst) !control_r.rxIrqEn |-> !rxIrq && !rxErrIrq;
  endproperty
  a_rxIrqOff: assert property (p_rxIrqOff) else $error("receive request without enable");
  property p_bit372;
    @(posedge clock) disable iff (rst)
      txStart && cardSel_r && (format_r.bitClockCount == BCC_372) |=> txCnt_r == (BCLK_372 - 9'h001);
  endproperty
  a_bit372: assert property (p_bit372) else $error("card bit time not 372 clocks");
  property p_normBit;
    @(posedge clock) disable iff (rst) !cardSel_r |-> bitLen == BCLK_NORM;
  endproperty
  a_normBit: assert property (p_normBit) else $error("normal mode bit time wrong");
  property p_div1;
    @(posedge clock) disable iff (rst) (format_r.brgSource == BRG_DIV1) |=> brgTick || !(format_r.brgSource == BRG_DIV1);
  endproperty
  a_div1: assert property (p_div1) else $error("undivided source missed a tick");
  property p_div4;
    @(posedge clock) disable iff (rst) brgTick && src4 |=> (!brgTick || !src4) [*3] ##1 (brgTick || !src4);
  endproperty
  a_div4: assert property (p_div4) else $error("divide by 4 spacing wrong");
  property p_div16;
    @(posedge clock) disable iff (rst) brgTick && src16 |=> (!brgTick || !src16) [*8];
  endproperty
  a_div16: assert property (p_div16) else $error("divide by 16 ticks too close");
  property p_rxOffHold;
    @(posedge clock) disable iff (rst) !control_r.rxOn && !wrStatus |=> $stable(rxFlags);
  endproperty
  a_rxOffHold: assert property (p_rxOffHold) else $error("receive flags moved while receive off");
  property p_rxStart;
    @(posedge clock) disable iff (rst) rxStartAsy |=> rxState_r == RX_START;
  endproperty
  a_rxStart: assert property (p_rxStart) else $error("start bit not taken");
endmodule : sfcb_top

// ---- sfcb_line_model.sv ----
// Serial line partner driving the receive pins
`timescale 1ns/1ps
module sfcb_line_model (
  // Clock
  input  wire logic clock,
  // Line toward the block
  output logic      rxd,
  output logic      sclkIn
);
  // Mark level between frames; serial clock stands still
  initial
  begin
    rxd = 1'b1;
    sclkIn = 1'b0;
  end
  // Start, data LSB first, parity, stop; odd flips the sense to force an error
  task automatic send(input logic [7:0] c, input logic odd, input int bitLen);
    logic [10:0] f;
    f = {1'b1, ^c ^ odd, c, 1'b0};
    for (int i = 0; i < 11; i++)
    begin
      rxd <= f[i];
      repeat (bitLen) @(posedge clock);
    end
  endtask : send
  // Clocked synchronous byte, LSB first, data set half a period before each rise
  task automatic clock_in(input logic [7:0] c, input int half);
    for (int i = 0; i < 8; i++)
    begin
      rxd <= c[i];
      repeat (half) @(posedge clock);
      sclkIn <= 1'b1;
      repeat (half) @(posedge clock);
      sclkIn <= 1'b0;
    end
    rxd <= 1'b1;
  endtask : clock_in
endmodule : sfcb_line_model

// ---- sfcb_top_tb.sv ----
// Self-checking bench for the serial format and control block
`timescale 1ns/1ps
module sfcb_top_tb;
  import sfcb_pkg::*;
  typedef struct packed {logic [7:0] a; logic [7:0] d; logic [7:0] q; logic [1:0] rsp;} sfcb_row_t;
  logic             clock = 1'b0, rst = 1'b1, awvalid = 1'b0, wvalid = 1'b0;
  logic             bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [7:0]       awaddr = 8'h00, araddr = 8'h00;
  logic [31:0]      wdata = 32'h0, v;
  logic [3:0]       wstrb = 4'hF;
  logic [1:0]       r;
  wire logic        awready, wready, bvalid, arready, rvalid, txd, rxd, sclkIn, txIrq, rxIrq, rxErrIrq, irq;
  wire logic [1:0]  bresp, rresp;
  wire logic [31:0] rdata;
  int               failures = 0, checkCount = 0;
  int               cardLen[4] = '{32, 64, 372, 256};
  sfcb_row_t        rows[5] = '{'{OFS_IRQ_MASK, 8'h07, 8'h07, RESP_OKAY}, '{OFS_CARD, 8'h01, 8'h01, RESP_OKAY},
    '{OFS_CARD, 8'h00, 8'h00, RESP_OKAY}, '{OFS_RXDATA, 8'hFF, 8'h00, RESP_OKAY}, '{8'h20, 8'h00, 8'h00, RESP_SLVERR}};
  sfcb_top        dut_u (.*);
  sfcb_line_model line_u (.clock(clock), .rxd(rxd), .sclkIn(sclkIn));
  // Clock; watchdog leaves room above the slowest divider
  always #50 clock = ~clock;
  initial
  begin
    #8_000_000;
    failures++;
    wrap_up();
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checkCount++;
    if (seen !== exp) begin failures++; $display("wrong value at %0t: saw %h want %h", $time, seen, exp); end
  endtask : chk
  // Both write channels offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] resp);
    logic aw, w;
    @(posedge clock);
    {awaddr, wdata, awvalid, wvalid, bready} <= {a, 24'h0, d, 3'b111};
    aw = 1'b1;
    w = 1'b1;
    do
    begin
      @(posedge clock);
      if (aw && awready) begin awvalid <= 1'b0; aw = 1'b0; end
      if (w && wready) begin wvalid <= 1'b0; w = 1'b0; end
    end while (aw || w);
    do @(posedge clock); while (bvalid !== 1'b1);
    bready <= 1'b0;
    resp = bresp;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clock);
    {araddr, arvalid, rready} <= {a, 2'b11};
    do @(posedge clock); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clock); while (rvalid !== 1'b1);
    rready <= 1'b0;
    d = rdata;
  endtask : rd
  // Format set with transmit off, then one character timed on the line
  task automatic txchk(input logic [7:0] f, input logic [7:0] c, input int len);
    logic [9:0] got;
    int         n;
    wr(OFS_CONTROL, 8'h00, r);
    wr(OFS_FORMAT, f, r);
    wr(OFS_CONTROL, 8'hA0, r);
    @(posedge clock);
    chk(txIrq, 1'b1);
    wr(OFS_TXDATA, c, r);
    rd(OFS_STATUS, v);
    chk(v, 32'h80);
    wr(OFS_STATUS, 8'h00, r);
    // Divider phase can cut the start bit short, so the first data bit is timed
    while (txd !== 1'b0) @(posedge clock);
    while (txd === 1'b0) @(posedge clock);
    got[0] = txd;
    n = 0;
    while (txd === 1'b1) begin @(posedge clock); n++; end
    chk(n, len);
    repeat (len / 2) @(posedge clock);
    for (int k = 1; k < 10; k++) begin got[k] = txd; repeat (len) @(posedge clock); end
    chk(got, {1'b1, f[5] ? ^c ^ f[4] : 1'b1, c});
    repeat (len) @(posedge clock);
  endtask : txchk
  task automatic wrap_up();
    $display("checks %0d, failures %0d", checkCount, failures);
    if (failures == 0 && checkCount > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : wrap_up
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    foreach (rows[i])
    begin
      wr(rows[i].a, rows[i].d, r);
      chk(r, rows[i].rsp);
      rd(rows[i].a, v);
      if (rows[i].rsp === RESP_OKAY) chk(v, rows[i].q);
    end
    // Registers still at reset value
    rd(OFS_FORMAT, v);
    chk(v, 32'h00);
    rd(OFS_CONTROL, v);
    chk(v, 32'h00);
    chk(irq, 1'b0);
    // Every divider in normal mode, parity off only at the fastest
    for (int b = 0; b < 4; b++) txchk({2'b00, b != 0, b[0], 2'b00, b[1:0]}, 8'h35, 16 << (2 * b));
    wr(OFS_CARD, 8'h01, r);
    for (int s = 0; s < 4; s++) txchk({4'h2, s[1:0], 2'b00}, 8'h0D, cardLen[s]);
    wr(OFS_CARD, 8'h00, r);
    // Good character, then a bad-parity one that overruns
    wr(OFS_CONTROL, 8'h00, r);
    wr(OFS_FORMAT, 8'h20, r);
    wr(OFS_CONTROL, 8'h50, r);
    line_u.send(8'hA5, 1'b0, 16);
    repeat (16) @(posedge clock);
    rd(OFS_RXDATA, v);
    chk(v, 32'hA5);
    chk(rxIrq, 1'b1);
    line_u.send(8'h5A, 1'b1, 16);
    repeat (16) @(posedge clock);
    chk(rxErrIrq, 1'b1);
    wr(OFS_CONTROL, 8'h40, r);
    rd(OFS_STATUS, v);
    chk(v, 32'hE0);
    wr(OFS_STATUS, 8'h00, r);
    @(posedge clock);
    chk({rxIrq, rxErrIrq}, 2'b00);
    // Bad parity on an empty buffer, then a clocked synchronous byte
    wr(OFS_CONTROL, 8'h50, r);
    line_u.send(8'h5A, 1'b1, 16);
    repeat (16) @(posedge clock);
    rd(OFS_STATUS, v);
    chk(v, 32'hC8);
    wr(OFS_STATUS, 8'h00, r);
    wr(OFS_CONTROL, 8'h00, r);
    wr(OFS_FORMAT, 8'h80, r);
    wr(OFS_CONTROL, 8'h50, r);
    line_u.clock_in(8'h3C, 4);
    repeat (4) @(posedge clock);
    rd(OFS_RXDATA, v);
    chk(v, 32'h3C);
    chk(irq, 1'b1);
    wr(OFS_IRQ_STAT, 8'h07, r);
    @(posedge clock);
    chk(irq, 1'b0);
    wrap_up();
  end
endmodule : sfcb_top_tb
